/* File: verilog/palette_regs.svh */
// register map, field positions and reset values of the colour palette pipeline
`ifndef PALETTE_REGS_SVH
`define PALETTE_REGS_SVH
// ----------------------------------------
// register select codes
// ----------------------------------------
`define RS_SET          2'h0
`define RS_INDEX        2'h1
`define RS_DATA         2'h2
// ----------------------------------------
// set codes
// ----------------------------------------
`define SET_RGB_WR      8'h00
`define SET_RGB_RD      8'h01
`define SET_PSEUDO_WR   8'h02
`define SET_PSEUDO_RD   8'h03
`define SET_OVL_WR      8'h20
`define SET_OVL_RD      8'h21
`define SET_PMASK       8'h40
`define SET_OMASK       8'h43
`define SET_DACCTL      8'h46
`define SET_PIXMODE     8'h49
`define SET_PAN         8'h4A
`define SET_COMP        8'h4B
`define SET_CKSUM_LO    8'h80
`define SET_CKSUM_MID   8'h81
`define SET_CKSUM_HI    8'h82
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SIZE_32         2'h0
`define SIZE_8          2'h1
`define SIZE_16         2'h2
`define ACCEL_MIN       3'h2
`define ACCEL_MAX       3'h5
`define DAC_SYNC_OFF    0
`define DAC_BLANK_OFF   1
`define DAC_SIX_BIT     2
`define INT_FULL        2'h0
`define INT_HALF        2'h1
`define INT_QUARTER     2'h2
`define BYTE_BLUE       2'h2
`define REG_RESET       8'h00
`endif

/* File: verilog/palette_pkg.sv */
// shared types of the colour palette pipeline
package palette_pkg;
   typedef logic [7:0] byte_t;
   // host read strobe phases: idle, driving, one extra hold cycle
   typedef enum logic [1:0] {RD_IDLE, RD_DRIVE, RD_HOLD} rd_phase_t;
endpackage

/* File: verilog/colour_palette_pipeline.sv */
// colour palette pipeline: pixel multiplexer, look-up channels, checksums and host port
`include "palette_regs.svh"
module colour_palette_pipeline (
   // clock and reset (clk is the dot clock)
   input  wire logic           clk,
   input  wire logic           sys_rst,
   // pixel interface pins (pixel_port_zero is bits 7:0)
   input  wire logic [159:0]   pixel_ports,
   input  wire logic [4:0]     field_choice_inputs,
   input  wire logic [9:0]     overlay_bits,
   input  wire logic           hsync_n,
   input  wire logic           vsync_n,
   input  wire logic           blank_n,
   // host programming port
   input  wire logic           wr_n,
   input  wire logic           rd_n,
   input  wire logic [1:0]     register_select_lines,
   input  wire logic [7:0]     host_data_in,
   output logic [7:0]          host_data_out,
   output logic                host_data_oe,
   // DAC input stream
   input  wire logic           dac_ready,
   output logic                dac_valid,
   output logic [7:0]          dac_red,
   output logic [7:0]          dac_green,
   output logic [7:0]          dac_blue,
   output logic                sync_offset_removed,
   output logic                blank_offset_removed,
   output logic                pixel_ready
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [159:0] pix_meta, pix_sync;
   logic [14:0]  side_meta, side_sync;   // selects, overlays
   logic [2:0]   sb_meta, sb_sync;       // hsync, vsync, blank
   logic [1:0]   st_meta, st_sync, st_prev;
   logic [1:0]   rs_meta, rs_sync;
   logic [7:0]   din_meta, din_sync;
   // two flops on every pin, a third on wr_n and rd_n for edge detection; the first stage never feeds logic
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pix_meta  <= '0;
         pix_sync  <= '0;
         side_meta <= '0;
         side_sync <= '0;
         sb_meta   <= 3'h7;
         sb_sync   <= 3'h7;
         st_meta   <= 2'h3;
         st_sync   <= 2'h3;
         st_prev   <= 2'h3;
         rs_meta   <= '0;
         rs_sync   <= '0;
         din_meta  <= '0;
         din_sync  <= '0;
      end else begin
         pix_meta  <= pixel_ports;
         pix_sync  <= pix_meta;
         side_meta <= {field_choice_inputs, overlay_bits};
         side_sync <= side_meta;
         sb_meta   <= {hsync_n, vsync_n, blank_n};
         sb_sync   <= sb_meta;
         st_meta   <= {wr_n, rd_n};
         st_sync   <= st_meta;
         st_prev   <= st_sync;
         rs_meta   <= register_select_lines;
         rs_sync   <= rs_meta;
         din_meta  <= host_data_in;
         din_sync  <= din_meta;
      end
   end

   logic wr_fall, wr_rise, rd_fall, rd_rise;
   assign wr_fall = st_prev[1] & ~st_sync[1];
   assign wr_rise = ~st_prev[1] & st_sync[1];
   assign rd_fall = st_prev[0] & ~st_sync[0];
   assign rd_rise = ~st_prev[0] & st_sync[0];

   // ----------------------------------------
   // tables; contents stay undefined after reset, while the checksums reset to zero
   // ----------------------------------------
   logic [7:0]  rgb_tab    [3][256];
   logic [7:0]  pseudo_tab [3][256];
   logic [7:0]  ovl_tab    [3][4];    // entry 0 never reaches the screen
   logic [23:0] cksum_reg  [3];

   // ----------------------------------------
   // host register file
   // ----------------------------------------
   logic [7:0] set_reg, set_next, index_reg, index_next;
   logic [1:0] cnt_reg, cnt_next, rs_reg, rs_next;
   logic [7:0] red_hold_reg, red_hold_next, grn_hold_reg, grn_hold_next;
   logic [7:0] pmask_reg, pmask_next;
   logic [1:0] omask_reg, omask_next, comp_reg, comp_next;
   logic [4:0] dac_reg, dac_next;
   logic [6:0] mode_reg, mode_next;
   logic [3:0] pan_reg, pan_next;
   logic [7:0] rdata_reg, rdata_next, rd_val;
   palette_pkg::rd_phase_t rd_reg, rd_next;
   logic       tab_we, set_is_table, set_is_24;

   // read mux over the full set/index address
   always_comb begin
      rd_val = 8'h00;
      case (rs_sync)
         `RS_SET:   rd_val = set_reg;
         `RS_INDEX: rd_val = index_reg;
         `RS_DATA: begin
            case (set_reg)
               `SET_RGB_RD:    rd_val = rgb_tab[cnt_reg][index_reg];
               `SET_PSEUDO_RD: rd_val = pseudo_tab[cnt_reg][index_reg];
               `SET_OVL_RD:    rd_val = ovl_tab[cnt_reg][index_reg[1:0]];
               `SET_PMASK:     rd_val = pmask_reg;
               `SET_OMASK:     rd_val = {6'h00, omask_reg};
               `SET_DACCTL:    rd_val = {3'h0, dac_reg};
               `SET_PIXMODE:   rd_val = {1'b0, mode_reg};
               `SET_PAN:       rd_val = {4'h0, pan_reg};
               `SET_COMP:      rd_val = {6'h00, comp_reg};
               `SET_CKSUM_LO:  rd_val = cksum_reg[cnt_reg][7:0];
               `SET_CKSUM_MID: rd_val = cksum_reg[cnt_reg][15:8];
               `SET_CKSUM_HI:  rd_val = cksum_reg[cnt_reg][23:16];
               default:        rd_val = 8'h00;
            endcase
         end
         default: rd_val = 8'h00;
      endcase
   end

   assign set_is_table = (set_reg == `SET_RGB_WR) | (set_reg == `SET_PSEUDO_WR) | (set_reg == `SET_OVL_WR);
   assign set_is_24 = (set_reg == `SET_RGB_RD) | (set_reg == `SET_PSEUDO_RD) | (set_reg == `SET_OVL_RD)
                    | (set_reg[7:2] == 6'h20 && set_reg[1:0] != 2'h3);

   // host sequencing: select lines on fall, data on write rise
   always_comb begin
      set_next      = set_reg;
      index_next    = index_reg;
      cnt_next      = cnt_reg;
      rs_next       = rs_reg;
      red_hold_next = red_hold_reg;
      grn_hold_next = grn_hold_reg;
      pmask_next    = pmask_reg;
      omask_next    = omask_reg;
      dac_next      = dac_reg;
      mode_next     = mode_reg;
      pan_next      = pan_reg;
      comp_next     = comp_reg;
      rdata_next    = rdata_reg;
      rd_next       = rd_reg;
      tab_we        = 1'b0;
      if (wr_fall) begin
         rs_next = rs_sync;
      end
      if (wr_rise) begin
         case (rs_reg)
            `RS_SET: begin
               set_next = din_sync;
               cnt_next = 2'h0;
            end
            `RS_INDEX: begin
               index_next = din_sync;
               cnt_next   = 2'h0;
            end
            `RS_DATA: begin
               if (set_is_table) begin
                  if (cnt_reg == 2'h0) begin
                     red_hold_next = din_sync;
                  end
                  if (cnt_reg == 2'h1) begin
                     grn_hold_next = din_sync;
                  end
                  if (cnt_reg == `BYTE_BLUE) begin
                     tab_we     = 1'b1;
                     index_next = index_reg + 8'h01;
                     cnt_next   = 2'h0;
                  end else begin
                     cnt_next = cnt_reg + 2'h1;
                  end
               end
               case (set_reg)
                  `SET_PMASK:   pmask_next = din_sync;
                  `SET_OMASK:   omask_next = din_sync[1:0];
                  `SET_DACCTL:  dac_next   = din_sync[4:0];
                  `SET_PIXMODE: mode_next  = din_sync[6:0];
                  `SET_PAN:     pan_next   = din_sync[3:0];
                  `SET_COMP:    comp_next  = din_sync[1:0];
                  default:      pmask_next = pmask_reg;
               endcase
            end
            default: rs_next = rs_reg;
         endcase
      end
      case (rd_reg)
         palette_pkg::RD_IDLE: begin
            if (rd_fall) begin
               rs_next    = rs_sync;
               rdata_next = rd_val;
               rd_next    = palette_pkg::RD_DRIVE;
            end
         end
         palette_pkg::RD_DRIVE: begin
            if (rd_rise) begin
               rd_next = palette_pkg::RD_HOLD;
               if (rs_reg == `RS_DATA && set_is_24) begin
                  if (cnt_reg == `BYTE_BLUE) begin
                     cnt_next   = 2'h0;
                     index_next = set_reg[7] ? index_reg : index_reg + 8'h01;
                  end else begin
                     cnt_next = cnt_reg + 2'h1;
                  end
               end
            end
         end
         palette_pkg::RD_HOLD: rd_next = palette_pkg::RD_IDLE;
         default:              rd_next = palette_pkg::RD_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         set_reg       <= `REG_RESET;
         index_reg     <= `REG_RESET;
         cnt_reg       <= 2'h0;
         rs_reg        <= 2'h0;
         red_hold_reg  <= `REG_RESET;
         grn_hold_reg  <= `REG_RESET;
         pmask_reg     <= `REG_RESET;
         omask_reg     <= 2'h0;
         dac_reg       <= 5'h00;
         mode_reg      <= 7'h00;
         pan_reg       <= 4'h0;
         comp_reg      <= 2'h0;
         rdata_reg     <= `REG_RESET;
         rd_reg        <= palette_pkg::RD_IDLE;
         host_data_out <= `REG_RESET;
         host_data_oe  <= 1'b0;
      end else begin
         set_reg       <= set_next;
         index_reg     <= index_next;
         cnt_reg       <= cnt_next;
         rs_reg        <= rs_next;
         red_hold_reg  <= red_hold_next;
         grn_hold_reg  <= grn_hold_next;
         pmask_reg     <= pmask_next;
         omask_reg     <= omask_next;
         dac_reg       <= dac_next;
         mode_reg      <= mode_next;
         pan_reg       <= pan_next;
         comp_reg      <= comp_next;
         rdata_reg     <= rdata_next;
         rd_reg        <= rd_next;
         host_data_out <= rdata_next;
         host_data_oe  <= (rd_next != palette_pkg::RD_IDLE);
      end
   end

   logic [23:0] tab_word;
   // red and green wait in holding registers until blue arrives
   assign tab_word = {red_hold_reg, grn_hold_reg, din_sync};

   // table writes commit all three colours on the blue byte
   always_ff @(posedge clk) begin
      for (int c = 0; c < 3; c++) begin
         if (tab_we) begin
            case (set_reg)
               `SET_RGB_WR:    rgb_tab[c][index_reg] <= tab_word[23 - 8 * c -: 8];
               `SET_PSEUDO_WR: pseudo_tab[c][index_reg] <= tab_word[23 - 8 * c -: 8];
               default:        ovl_tab[c][index_reg[1:0]] <= tab_word[23 - 8 * c -: 8];
            endcase
         end
      end
   end

   // ----------------------------------------
   // pixel multiplexer and dot sequencing
   // ----------------------------------------
   logic [159:0] pix_cap_reg, pix_cap_next;
   logic [14:0]  side_cap_reg, side_cap_next;
   logic [2:0]   sb_cap_reg, sb_cap_next;
   logic [2:0]   dot_reg, dot_next, accel, last_dot;
   logic         advance, sample_en, vs_rise, use_pseudo;
   logic [31:0]  word32;
   logic [7:0]   pseudo_raw, masked;
   logic [1:0]   ovl_sel;
   logic [7:0]   chan_in [3];
   logic [7:0]   chan_out [3];
   logic [25:0]  push_data;

   // out-of-range factors clamp to the nearest legal one
   assign accel    = (mode_reg[4:2] < `ACCEL_MIN) ? `ACCEL_MIN
                   : (mode_reg[4:2] > `ACCEL_MAX) ? `ACCEL_MAX : mode_reg[4:2];
   assign last_dot = accel - 3'h1;
   assign sample_en = advance & (dot_reg == last_dot);
   assign vs_rise   = sample_en & sb_sync[1] & ~sb_cap_reg[1];

   // the capture group waits while the buffer stalls
   always_comb begin
      dot_next      = dot_reg;
      pix_cap_next  = pix_cap_reg;
      side_cap_next = side_cap_reg;
      sb_cap_next   = sb_cap_reg;
      if (advance) begin
         dot_next = (dot_reg == last_dot) ? 3'h0 : dot_reg + 3'h1;
      end
      if (sample_en) begin
         pix_cap_next  = pix_sync;
         side_cap_next = side_sync;
         sb_cap_next   = sb_sync;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dot_reg      <= 3'h0;
         pix_cap_reg  <= '0;
         side_cap_reg <= '0;
         sb_cap_reg   <= 3'h7;
      end else begin
         dot_reg      <= dot_next;
         pix_cap_reg  <= pix_cap_next;
         side_cap_reg <= side_cap_next;
         sb_cap_reg   <= sb_cap_next;
      end
   end

   // slot extraction for the current dot
   always_comb begin
      word32 = 32'h0000_0000;
      case (mode_reg[1:0])
         `SIZE_8:  word32 = {24'h00_0000, pix_cap_reg[dot_reg * 8 +: 8]};
         `SIZE_16: word32 = {16'h0000, pix_cap_reg[dot_reg * 16 +: 16]};
         default:  word32 = pix_cap_reg[dot_reg * 32 +: 32];
      endcase
      pseudo_raw = word32[mode_reg[6:5] * 8 +: 8];
      masked     = pseudo_raw & pmask_reg;
      ovl_sel    = side_cap_reg[dot_reg * 2 +: 2] & omask_reg;
      if (mode_reg[1:0] == `SIZE_16) begin
         chan_in[0] = {word32[15:10], 2'h0};
         chan_in[1] = {word32[9:4], 2'h0};
         chan_in[2] = {word32[3:0], 4'h0};
      end else begin
         chan_in[0] = word32[31:24];
         chan_in[1] = word32[23:16];
         chan_in[2] = word32[15:8];
      end
      if (mode_reg[1:0] == `SIZE_8) begin
         use_pseudo = 1'b1;
      end else if (mode_reg[1:0] == `SIZE_32) begin
         use_pseudo = comp_reg[0] ? side_cap_reg[10 + dot_reg] : (masked != 8'h00);
      end else begin
         use_pseudo = 1'b0;
      end
   end

   // ----------------------------------------
   // colour channels and checksums
   // ----------------------------------------
   for (genvar c = 0; c < 3; c++) begin : g_chan
      logic [7:0]  look, shaped;
      logic [23:0] sum_next;
      always_comb begin
         look = 8'h00;
         if (ovl_sel != 2'h0) begin
            look = ovl_tab[c][ovl_sel];
         end else if (use_pseudo) begin
            look = pseudo_tab[c][masked];
         end else begin
            look = rgb_tab[c][chan_in[c]];
         end
         shaped = dac_reg[`DAC_SIX_BIT] ? {look[7:2], 2'h0} : look;
         case (dac_reg[4:3])
            `INT_FULL:    chan_out[c] = shaped;
            `INT_HALF:    chan_out[c] = {1'b0, shaped[7:1]};
            `INT_QUARTER: chan_out[c] = {2'h0, shaped[7:2]};
            default:      chan_out[c] = 8'h00;
         endcase
         if (!sb_cap_reg[0]) begin
            chan_out[c] = 8'h00;
         end
         sum_next = cksum_reg[c];
         if (vs_rise) begin
            sum_next = 24'h00_0000;
         end else if (advance && sb_cap_reg[0]) begin
            sum_next = cksum_reg[c] + {16'h0000, chan_out[c]};
         end
      end
      always_ff @(posedge clk or posedge sys_rst) begin
         if (sys_rst) begin
            cksum_reg[c] <= 24'h00_0000;
         end else begin
            cksum_reg[c] <= sum_next;
         end
      end
   end

   // pedestal flags travel with the colour
   assign push_data = {(~sb_cap_reg[2] | ~sb_cap_reg[1]) & ~dac_reg[`DAC_SYNC_OFF],
                       ~sb_cap_reg[0] & ~dac_reg[`DAC_BLANK_OFF],
                       chan_out[0], chan_out[1], chan_out[2]};

   // ----------------------------------------
   // two-entry output buffer; head drives the DAC ports
   // ----------------------------------------
   logic [1:0]  count_reg, count_next;
   logic [25:0] head_reg, head_next, tail_reg, tail_next;
   logic        pop;

   // a full buffer stops the dot sequencer, so no word is dropped
   assign advance = (count_reg != 2'h2);
   assign pop     = dac_ready & (count_reg != 2'h0);

   always_comb begin
      head_next  = head_reg;
      tail_next  = tail_reg;
      count_next = count_reg;
      case ({advance, pop})
         2'b10: begin
            if (count_reg == 2'h0) begin
               head_next = push_data;
            end else begin
               tail_next = push_data;
            end
            count_next = count_reg + 2'h1;
         end
         2'b01: begin
            head_next  = tail_reg;
            count_next = count_reg - 2'h1;
         end
         2'b11: begin
            head_next = (count_reg == 2'h1) ? push_data : tail_reg;
         end
         default: count_next = count_reg;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_reg   <= 2'h0;
         head_reg    <= '0;
         tail_reg    <= '0;
         dac_valid   <= 1'b0;
         pixel_ready <= 1'b0;
      end else begin
         count_reg   <= count_next;
         head_reg    <= head_next;
         tail_reg    <= tail_next;
         dac_valid   <= (count_next != 2'h0);
         pixel_ready <= (count_next != 2'h2);
      end
   end

   assign {sync_offset_removed, blank_offset_removed, dac_red, dac_green, dac_blue} = head_reg;

endmodule // colour_palette_pipeline

/* File: verif/palette_monitor.sv */
// port assertions and covers for the colour palette pipeline
module palette_monitor (
   // clock and reset
   input wire logic       clk,
   input wire logic       sys_rst,
   // host strobes and bus
   input wire logic       wr_n,
   input wire logic       rd_n,
   input wire logic [7:0] host_data_out,
   input wire logic       host_data_oe,
   // dac stream
   input wire logic       dac_ready,
   input wire logic       dac_valid,
   input wire logic [7:0] dac_red,
   input wire logic       pixel_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // ----
   // stream buffer, guarded after reset since flags start low
   // ----
   a_stall_keeps_word: assert property (dac_valid && !dac_ready |=> dac_valid && $stable(dac_red))
      else $error("dac word lost under stall");
   a_full_has_head: assert property (!pixel_ready && !$past(sys_rst) |-> dac_valid)
      else $error("buffer full without head word");
   a_empty_not_full: assert property (!dac_valid && !$past(sys_rst) |-> pixel_ready)
      else $error("empty buffer refuses data");
   // ----
   // host port
   // ----
   a_read_answers: assert property ($fell(rd_n) |-> ##[2:5] host_data_oe)
      else $error("read strobe not answered");
   a_oe_needs_read: assert property ($rose(host_data_oe) |-> !$past(rd_n, 3))
      else $error("bus driven without read");
   a_read_release: assert property ($rose(rd_n) |-> ##[3:7] !host_data_oe)
      else $error("bus not released");
   a_read_hold: assert property ($rose(rd_n) |-> host_data_oe[*2])
      else $error("read data dropped at strobe rise");
   a_read_stable: assert property (host_data_oe && $past(host_data_oe) |-> $stable(host_data_out))
      else $error("read data changed while driven");
   a_write_quiet: assert property ((!wr_n && rd_n)[*8] |-> !host_data_oe)
      else $error("bus driven during write");
   c_read: cover property ($fell(rd_n));
   c_stall: cover property (dac_valid && !dac_ready);
   c_full: cover property (!pixel_ready);
endmodule // palette_monitor

bind colour_palette_pipeline palette_monitor mon (.clk, .sys_rst, .wr_n, .rd_n, .host_data_out,
   .host_data_oe, .dac_ready, .dac_valid, .dac_red, .pixel_ready);

/* File: verif/dac_sink.sv */
// dac-side sink that stalls one dot in three
module dac_sink (
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // stream handshake
   input  wire logic dac_valid,
   output logic      dac_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] phase_reg;
   // pops two words in three dots so the two-entry buffer fills up
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         phase_reg <= 2'h0;
      else
         phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
   end
   assign dac_ready = (phase_reg != 2'h2);
endmodule // dac_sink

/* File: verif/colour_palette_pipeline_tb.sv */
// self-checking bench for the colour palette pipeline
`include "palette_regs.svh"
module colour_palette_pipeline_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // blank starts low so unprogrammed tables reach the dac ports only in the first dots after reset, until the low blank is captured
   logic clk = 1'b0, sys_rst = 1'b1, hsync_n = 1'b1, vsync_n = 1'b1, blank_n = 1'b0, wr_n = 1'b1, rd_n = 1'b1;
   logic [159:0] pixel_ports = '0;
   logic [4:0] field_choice_inputs = '0;
   logic [9:0] overlay_bits = '0;
   logic [1:0] register_select_lines = 2'h0;
   palette_pkg::byte_t host_data_in = 8'h00, host_data_out, dac_red, dac_green, dac_blue, rd_val;
   logic host_data_oe, dac_ready, dac_valid, sync_offset_removed, blank_offset_removed, pixel_ready;
   int n_fail = 0, total_checks = 0, cycles = 0;
   always #50 clk = ~clk;
   colour_palette_pipeline uut (.clk, .sys_rst, .pixel_ports, .field_choice_inputs, .overlay_bits, .hsync_n,
      .vsync_n, .blank_n, .wr_n, .rd_n, .register_select_lines, .host_data_in, .host_data_out, .host_data_oe,
      .dac_ready, .dac_valid, .dac_red, .dac_green, .dac_blue, .sync_offset_removed, .blank_offset_removed,
      .pixel_ready);
   dac_sink sink (.clk, .sys_rst, .dac_valid, .dac_ready);
   // ----
   // shared tasks: strobes held well past the two-flop synchroniser
   // ----
   task automatic chk(input string what, input palette_pkg::byte_t exp, got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic hwr(input logic [1:0] sel, input palette_pkg::byte_t d);
      @(negedge clk);
      register_select_lines = sel;
      host_data_in = d;
      wr_n = 1'b0;
      repeat (5) @(negedge clk);
      wr_n = 1'b1;
      repeat (5) @(negedge clk);
   endtask
   task automatic rdchk(input string what, input logic [1:0] sel, input palette_pkg::byte_t exp);
      @(negedge clk);
      register_select_lines = sel;
      rd_n = 1'b0;
      repeat (6) @(negedge clk);
      rd_val = host_data_out;
      rd_n = 1'b1;
      repeat (7) @(negedge clk);
      chk(what, exp, rd_val);
   endtask
   task automatic tw(input palette_pkg::byte_t s, i, r, g, b);
      hwr(`RS_SET, s);
      hwr(`RS_INDEX, i);
      hwr(`RS_DATA, r);
      hwr(`RS_DATA, g);
      hwr(`RS_DATA, b);
   endtask
   // single-location sets skip the index write
   task automatic wreg(input palette_pkg::byte_t s, d);
      hwr(`RS_SET, s);
      hwr(`RS_DATA, d);
   endtask
   task automatic show(input palette_pkg::byte_t r, g, b);
      repeat (20) @(negedge clk);
      chk("dac red", r, dac_red);
      chk("dac green", g, dac_green);
      chk("dac blue", b, dac_blue);
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_registers;
      rdchk("set after reset", `RS_SET, `REG_RESET);
      hwr(`RS_SET, `SET_PMASK);
      hwr(`RS_DATA, 8'hA5);
      rdchk("pseudo mask", `RS_DATA, 8'hA5);
      rdchk("set readback", `RS_SET, `SET_PMASK);
      rdchk("reserved select", 2'h3, 8'h00);
      hwr(`RS_SET, `SET_DACCTL);
      hwr(`RS_DATA, 8'hFF);
      rdchk("dac control", `RS_DATA, 8'h1F);
      hwr(`RS_DATA, 8'h00);
   endtask
   task automatic t_tables;
      tw(`SET_RGB_WR, 8'h05, 8'h10, 8'h11, 8'h12);
      for (int i = 3; i < 6; i++) hwr(`RS_DATA, 8'h10 + i[7:0]);
      tw(`SET_RGB_RD, 8'h05, 8'h00, 8'h00, 8'h00);
      for (int i = 0; i < 6; i++) rdchk("rgb table", `RS_DATA, 8'h10 + i[7:0]);
      hwr(`RS_INDEX, 8'h05);
      rdchk("red after index write", `RS_DATA, 8'h10);
   endtask
   task automatic t_video;
      tw(`SET_PSEUDO_WR, 8'h11, 8'h2A, 8'h3B, 8'h4C);
      tw(`SET_PSEUDO_WR, 8'h01, 8'h05, 8'h06, 8'h07);
      tw(`SET_OVL_WR, 8'h01, 8'h70, 8'h71, 8'h72);
      wreg(`SET_PMASK, 8'hFF);
      wreg(`SET_PIXMODE, 8'h09);
      pixel_ports = {20{8'h11}};
      overlay_bits = {5{2'h1}};
      // only now does every lookup hit a programmed entry
      blank_n = 1'b1;
      show(8'h2A, 8'h3B, 8'h4C);
      wreg(`SET_PMASK, 8'h01);
      show(8'h05, 8'h06, 8'h07);
      pixel_ports = {20{8'h05}};
      wreg(`SET_PIXMODE, 8'h08);
      show(8'h05, 8'h06, 8'h07);
      wreg(`SET_COMP, 8'h01);
      show(8'h10, 8'h11, 8'h12);
      field_choice_inputs = 5'h1F;
      show(8'h05, 8'h06, 8'h07);
      wreg(`SET_COMP, 8'h00);
      wreg(`SET_PMASK, 8'h00);
      show(8'h10, 8'h11, 8'h12);
      wreg(`SET_OMASK, 8'h03);
      show(8'h70, 8'h71, 8'h72);
      wreg(`SET_DACCTL, 8'h0C);
      show(8'h38, 8'h38, 8'h38);
      hsync_n = 1'b0;
      repeat (20) @(negedge clk);
      chk("sync offset", 8'h01, {7'h00, sync_offset_removed});
      hsync_n = 1'b1;
      blank_n = 1'b0;
      show(8'h00, 8'h00, 8'h00);
      chk("blank offset", 8'h01, {7'h00, blank_offset_removed});
      // vsync rise clears the sums; blank stays low so nothing is added after
      vsync_n = 1'b0;
      repeat (10) @(negedge clk);
      vsync_n = 1'b1;
      hwr(`RS_SET, `SET_CKSUM_LO);
      for (int i = 0; i < 3; i++) rdchk("checksum low byte", `RS_DATA, 8'h00);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // hang guard well above the thousand or so dots the scenarios need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         wrap_up();
      end
   end
   initial begin
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      t_registers();
      t_tables();
      t_video();
      wrap_up();
   end
endmodule // colour_palette_pipeline_tb
